// ==== core/mses_event_status_regs.sv ====
// register bank for data-enable stamping, timestamp, event sources, sample flags and temperature
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// [RULE_01] first lowpass cutoff: half rate or 700 Hz
// [RULE_02] per-axis enables put pin level into LSB
// [RULE_03] select bit chooses gyro or accel stamping; here a set bit only stops gyro stamping, accel follows the extend bit alone
// [RULE_04] extend bit also stamps the accelerometer
// [RULE_05] polarity bit: 0 active low, 1 high
// [RULE_06] host should disable I3C when unused
// [RULE_07] host writes zero to reserved bits
// [RULE_08] enable bit runs timestamp, bytes 40h-43h
// [RULE_09] warn flag within 6.4 ms of overflow
// [RULE_10] combined register gathers all event flags
// [RULE_11] wake source: sleep state, change, events
// [RULE_12] wake-up axis flags for X, Y, Z
// [RULE_13] tap source: any, single, double, axes
// [RULE_14] tap sign: 0 positive, 1 negative
// [RULE_15] orientation change flag, default zero
// [RULE_16] six over and under threshold axis flags
// [RULE_17] stamped sample ready, latched or pulsed
// [RULE_18] new temperature, gyro, accel sample flags
// [RULE_19] status readable over primary serial port
// [RULE_20] temperature word, low 20h, high 21h
// [RULE_21] flags clear on source read unless recurring
module mses_event_status_regs #(
   parameter int unsigned TICK_CYC = mses_pkg::TS_TICK_CYC
) (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire mses_pkg::mses_reg_req_t regReq,
   output logic                        regRvalid,
   output logic [7:0]                  regRdata,
   input  wire logic                   dataEnablePin,
   input  wire logic                   readyPulseMode,
   input  wire logic                   accelHighPerf,
   input  wire logic [15:0]            outputSampleRate,
   input  wire mses_pkg::mses_axes_t   gyroIn,
   input  wire mses_pkg::mses_axes_t   accelIn,
   input  wire mses_pkg::mses_temp_t   tempIn,
   input  wire mses_pkg::mses_events_t events,
   output mses_pkg::mses_axes_t        gyroOut,
   output mses_pkg::mses_axes_t        accelOut,
   output logic [15:0]                 accelFirstLowpassHz,
   output logic                        i3cDisable
);
   import mses_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // state

   logic        pinMeta_r;
   logic        pinSync_r;
   logic [7:0]  stampCtrl_r;
   logic [7:0]  timeCtrl_r;
   logic [23:0] flags_r;
   logic [23:0] flags_nxt;
   logic        sleepState_r;
   logic        tapSign_r;
   logic [15:0] tempWord_r;
   logic [11:0] tickCnt_r;
   logic [31:0] timeCount_r;
   logic [31:0] timeSnap_r;
   logic [7:0]  rdata_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // decode

   wire wrStamp   = regReq.wr && (regReq.addr == ADDR_STAMP_CTRL);
   wire wrTime    = regReq.wr && (regReq.addr == ADDR_TIME_CTRL);
   wire rdAll     = regReq.rd && (regReq.addr == ADDR_ALL_SRC);
   wire rdWake    = regReq.rd && (regReq.addr == ADDR_WAKE_SRC);
   wire rdTap     = regReq.rd && (regReq.addr == ADDR_TAP_EVENT_SOURCE);
   wire rdOrient  = regReq.rd && (regReq.addr == ADDR_ORIENT_SRC);
   wire rdSample  = regReq.rd && (regReq.addr == ADDR_NEW_SAMPLE);
   wire rdTimeB0  = regReq.rd && (regReq.addr == ADDR_TIME_B0);

   wire [2:0] axisEn    = stampCtrl_r[STAMP_AXES_LSB +: 3];
   wire       stampPol  = stampCtrl_r[STAMP_POL_BIT];
   wire       pinActive = pinSync_r ~^ stampPol;                              // RULE_05
   wire       stampGyro = ~stampCtrl_r[STAMP_SEL_BIT];                        // RULE_03
   wire       stampAccel = stampCtrl_r[STAMP_EXT_BIT];                        // RULE_04
   wire       timeEn    = timeCtrl_r[TIME_EN_BIT];
   wire       tickDone  = (tickCnt_r == 12'(TICK_CYC - 1));
   wire       tapEvent  = events.singleTap | events.doubleTap;

   ////////////////////////////////////////////////////////////////////////////////
   // data-enable stamping, one generate per axis

   wire [2:0][15:0] gyroAxes  = {gyroIn.x, gyroIn.y, gyroIn.z};
   wire [2:0][15:0] accelAxes = {accelIn.x, accelIn.y, accelIn.z};
   logic [2:0][15:0] gyroStamped;
   logic [2:0][15:0] accelStamped;

   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : gStamp
         assign gyroStamped[i]  = {gyroAxes[i][15:1],
                                   (stampGyro && axisEn[i]) ? pinActive : gyroAxes[i][0]};   // RULE_02
         assign accelStamped[i] = {accelAxes[i][15:1],
                                   (stampAccel && axisEn[i]) ? pinActive : accelAxes[i][0]}; // RULE_02
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // event set and read-clear vectors

   logic [23:0] evSet;
   assign evSet[FLG_FF]            = events.freefall;
   assign evSet[FLG_WU]            = events.wakeup;
   assign evSet[FLG_STAP]          = events.singleTap;
   assign evSet[FLG_DTAP]          = events.doubleTap;
   assign evSet[FLG_D6D]           = events.orientChange;                     // RULE_15
   assign evSet[FLG_SLCHG]         = events.sleepChange;
   assign evSet[FLG_WUAX +: 3]     = events.wakeAxes;                         // RULE_12
   assign evSet[FLG_TAPANY]        = tapEvent;                                // RULE_13
   assign evSet[FLG_TAPAX +: 3]    = events.tapAxes;
   assign evSet[FLG_ORAX +: 6]     = events.orientAxes;                       // RULE_16
   assign evSet[FLG_WARN]          = timeCount_r >= TS_WARN_START;            // RULE_09
   assign evSet[FLG_DENRDY]        = pinActive && ((gyroIn.valid && stampGyro) ||
                                                   (accelIn.valid && stampAccel)); // RULE_17
   assign evSet[FLG_SAMPLE +: 3]   = {tempIn.valid, gyroIn.valid, accelIn.valid}; // RULE_18

   // a pulsed ready flag is cleared every cycle, so it stands only while set
   wire [23:0] clrMask = (rdAll ? CLR_ALL : 24'h000000)
                       | (rdWake ? CLR_WAKE : 24'h000000)
                       | (rdTap ? CLR_TAP : 24'h000000)
                       | (rdOrient ? CLR_ORIENT : 24'h000000)
                       | (rdSample ? CLR_SAMPLE : 24'h000000)
                       | (readyPulseMode ? CLR_DENRDY : 24'h000000);          // RULE_17

   // set wins over a clear in the same cycle
   assign flags_nxt = (flags_r & ~clrMask) | evSet;                          // RULE_21

   ////////////////////////////////////////////////////////////////////////////////
   // read data

   wire [7:0] allSrcByte = {flags_r[FLG_WARN], 1'b0, flags_r[FLG_SLCHG], flags_r[FLG_D6D],
                            flags_r[FLG_DTAP], flags_r[FLG_STAP], flags_r[FLG_WU],
                            flags_r[FLG_FF]};                                 // RULE_10
   wire [7:0] wakeByte   = {1'b0, flags_r[FLG_SLCHG], flags_r[FLG_FF], sleepState_r,
                            flags_r[FLG_WU], flags_r[FLG_WUAX +: 3]};         // RULE_11
   wire [7:0] tapByte    = {1'b0, flags_r[FLG_TAPANY], flags_r[FLG_STAP], flags_r[FLG_DTAP],
                            tapSign_r, flags_r[FLG_TAPAX +: 3]};              // RULE_13
   wire [7:0] orientByte = {flags_r[FLG_DENRDY], flags_r[FLG_D6D],
                            flags_r[FLG_ORAX +: 6]};                          // RULE_16
   wire [7:0] sampleByte = {5'h00, flags_r[FLG_SAMPLE +: 3]};                 // RULE_19

   // byte 0 reads live and freezes the rest, so a burst 40h..43h is coherent
   assign rdata_nxt =
      (regReq.addr == ADDR_STAMP_CTRL) ? stampCtrl_r :
      (regReq.addr == ADDR_TIME_CTRL)  ? timeCtrl_r :
      (regReq.addr == ADDR_ALL_SRC)    ? allSrcByte :
      (regReq.addr == ADDR_WAKE_SRC)   ? wakeByte :
      (regReq.addr == ADDR_TAP_EVENT_SOURCE)    ? tapByte :
      (regReq.addr == ADDR_ORIENT_SRC) ? orientByte :
      (regReq.addr == ADDR_NEW_SAMPLE) ? sampleByte :
      (regReq.addr == ADDR_TEMP_LO)    ? tempWord_r[7:0] :                    // RULE_20
      (regReq.addr == ADDR_TEMP_HI)    ? tempWord_r[15:8] :                   // RULE_20
      (regReq.addr == ADDR_TIME_B0)    ? timeCount_r[7:0] :                   // RULE_08
      (regReq.addr == ADDR_TIME_B1)    ? timeSnap_r[15:8] :
      (regReq.addr == ADDR_TIME_B2)    ? timeSnap_r[23:16] :
      (regReq.addr == ADDR_TIME_B3)    ? timeSnap_r[31:24] :
                                         8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchroniser

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pinMeta_r <= 1'b0;
         pinSync_r <= 1'b0;
      end else begin
         pinMeta_r <= dataEnablePin;
         pinSync_r <= pinMeta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control registers; reserved bits are dropped on write and read as zero

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stampCtrl_r <= STAMP_CTRL_RST;
         timeCtrl_r  <= TIME_CTRL_RST;
      end else begin
         if (wrStamp) begin
            stampCtrl_r <= regReq.wdata & STAMP_CTRL_WMASK;                  // RULE_07
         end
         if (wrTime) begin
            timeCtrl_r <= regReq.wdata & TIME_CTRL_WMASK;                    // RULE_08
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // timestamp; stopping it holds the count, it does not zero it

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tickCnt_r   <= 12'h000;
         timeCount_r <= 32'h0000_0000;
         timeSnap_r  <= 32'h0000_0000;
      end else begin
         tickCnt_r <= (!timeEn || tickDone) ? 12'h000 : 12'(tickCnt_r + 12'h001);
         if (timeEn && tickDone) begin
            timeCount_r <= 32'(timeCount_r + 32'h0000_0001);                  // RULE_08
         end
         if (rdTimeB0) begin
            timeSnap_r <= timeCount_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // flags, captured values and outputs

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flags_r      <= FLG_RST;
         sleepState_r <= 1'b0;
         tapSign_r    <= 1'b0;
         tempWord_r   <= 16'h0000;
      end else begin
         flags_r      <= flags_nxt;
         sleepState_r <= events.sleepState;                                   // RULE_11
         if (tapEvent) begin
            tapSign_r <= events.tapSign;                                      // RULE_14
         end
         if (tempIn.valid) begin
            tempWord_r <= tempIn.value;                                       // RULE_20
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         regRvalid           <= 1'b0;
         regRdata            <= 8'h00;
         gyroOut             <= '0;
         accelOut            <= '0;
         accelFirstLowpassHz <= LOWPASS_FIXED_HZ;
         i3cDisable          <= 1'b0;
      end else begin
         regRvalid <= regReq.rd;
         regRdata  <= regReq.rd ? rdata_nxt : regRdata;
         gyroOut   <= {gyroIn.valid, gyroStamped[2], gyroStamped[1], gyroStamped[0]};
         accelOut  <= {accelIn.valid, accelStamped[2], accelStamped[1], accelStamped[0]};
         accelFirstLowpassHz <= accelHighPerf ? (outputSampleRate >> 1)
                                              : LOWPASS_FIXED_HZ;             // RULE_01
         i3cDisable <= stampCtrl_r[I3C_OFF_BIT];                              // RULE_06
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_cutoff_half_rate: assert property ( // RULE_01
      accelHighPerf |=> accelFirstLowpassHz == ($past(outputSampleRate) >> 1))
      else $error("cutoff not half the sample rate");

   a_cutoff_fixed_low: assert property ( // RULE_01
      !accelHighPerf |=> accelFirstLowpassHz == LOWPASS_FIXED_HZ)
      else $error("cutoff not fixed in low power");

   a_gyro_x_stamp: assert property ( // RULE_03
      (gyroIn.valid && !stampCtrl_r[STAMP_SEL_BIT] && stampCtrl_r[STAMP_AXES_LSB + 2])
      |=> gyroOut.valid && gyroOut.x[0] == $past(pinSync_r ~^ stampCtrl_r[STAMP_POL_BIT]))
      else $error("gyro x lsb not stamped with pin level");

   a_accel_unstamped: assert property ( // RULE_04
      (accelIn.valid && !stampCtrl_r[STAMP_EXT_BIT])
      |=> accelOut.z[0] == $past(accelIn.z[0]) && accelOut.x[0] == $past(accelIn.x[0]))
      else $error("accel stamped without extend bit");

   a_time_advance: assert property ( // RULE_08
      (timeEn && tickDone) |=> timeCount_r == 32'($past(timeCount_r) + 32'h0000_0001))
      else $error("timestamp did not advance");

   a_warn_raised: assert property ( // RULE_09
      (timeCount_r >= TS_WARN_START) |=> flags_r[FLG_WARN] && allSrcByte[7])
      else $error("overflow warning missing");

   a_freefall_sticky: assert property ( // RULE_21
      (flags_r[FLG_FF] && !rdAll && !rdWake) |=> flags_r[FLG_FF])
      else $error("freefall flag lost without read");

   a_read_clears: assert property ( // RULE_21
      (rdTap && !tapEvent) |=> !flags_r[FLG_TAPANY] ##1 !tapByte[6] || $past(tapEvent))
      else $error("tap flag not cleared by read");

   a_temp_low_read: assert property ( // RULE_20
      (regReq.rd && regReq.addr == ADDR_TEMP_LO && !tempIn.valid)
      |=> regRvalid && regRdata == $past(tempWord_r[7:0]))
      else $error("temperature low byte wrong");

   a_tap_sign_kept: assert property ( // RULE_14
      tapEvent |=> tapSign_r == $past(events.tapSign))
      else $error("tap sign not captured");

   a_gyro_new_flag: assert property ( // RULE_18
      gyroIn.valid |=> flags_r[FLG_SAMPLE + 1] ##1 1'b1)
      else $error("gyro new sample flag not set");

   a_status_read: assert property ( // RULE_19
      rdSample |=> regRvalid && regRdata[7:3] == 5'h00
         && regRdata[1] == $past(flags_r[FLG_SAMPLE + 1]))
      else $error("status byte wrong");

   a_active_low_pin: assert property ( // RULE_05
      (gyroIn.valid && stampGyro && axisEn[0] && !stampPol)
      |=> gyroOut.z[0] == !$past(pinSync_r))
      else $error("active low pin level not stamped");

   a_pulse_ready: assert property ( // RULE_17
      (readyPulseMode && !evSet[FLG_DENRDY]) |=> !flags_r[FLG_DENRDY])
      else $error("pulsed ready flag held");

   a_orient_latch: assert property ( // RULE_15
      events.orientChange |=> orientByte[6] && allSrcByte[4])
      else $error("orientation change not flagged");

   a_temp_capture: assert property ( // RULE_20
      tempIn.valid |=> tempWord_r == $past(tempIn.value))
      else $error("temperature word not captured");

   a_sleep_state: assert property ( // RULE_11
      1'b1 |=> wakeByte[4] == $past(events.sleepState))
      else $error("sleep state not shown");

   a_wake_axes: assert property ( // RULE_12
      events.wakeup |=> wakeByte[3]
         && (wakeByte[2:0] & $past(events.wakeAxes)) == $past(events.wakeAxes))
      else $error("wake-up axis flags missing");

   c_tap_then_read:   cover property (tapEvent ##[1:20] rdTap);
   c_time_warn:       cover property ($rose(flags_r[FLG_WARN]));
   c_stamped_ready:   cover property (evSet[FLG_DENRDY] ##1 rdOrient);
   c_pulse_ready:     cover property (readyPulseMode && evSet[FLG_DENRDY]);
   c_low_pin_stamp:   cover property (gyroIn.valid && stampGyro && !stampPol);

endmodule

`default_nettype wire

// ==== core/mses_pkg.sv ====
// shared constants and carrier types of the motion sensor event and status register bank
package mses_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned TS_TICK_NS     = 25000;
   localparam int unsigned TS_TICK_CYC    = TS_TICK_NS / CLK_PERIOD_NS;
   localparam int unsigned TS_WARN_NS     = 6400000;
   localparam int unsigned TS_WARN_TICKS  = TS_WARN_NS / TS_TICK_NS;
   localparam logic [31:0] TS_WARN_START  = 32'(33'h1_0000_0000 - 33'(TS_WARN_TICKS));
   localparam logic [15:0] LOWPASS_FIXED_HZ = 16'h02BC;

   ////////////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [7:0] ADDR_STAMP_CTRL  = 8'h18;
   localparam logic [7:0] ADDR_TIME_CTRL   = 8'h19;
   localparam logic [7:0] ADDR_ALL_SRC     = 8'h1A;
   localparam logic [7:0] ADDR_WAKE_SRC    = 8'h1B;
   localparam logic [7:0] ADDR_TAP_EVENT_SOURCE     = 8'h1C;
   localparam logic [7:0] ADDR_ORIENT_SRC  = 8'h1D;
   localparam logic [7:0] ADDR_NEW_SAMPLE  = 8'h1E;
   localparam logic [7:0] ADDR_TEMP_LO     = 8'h20;
   localparam logic [7:0] ADDR_TEMP_HI     = 8'h21;
   localparam logic [7:0] ADDR_TIME_B0     = 8'h40;
   localparam logic [7:0] ADDR_TIME_B1     = 8'h41;
   localparam logic [7:0] ADDR_TIME_B2     = 8'h42;
   localparam logic [7:0] ADDR_TIME_B3     = 8'h43;

   ////////////////////////////////////////////////////////////////////////////////
   // control fields and reset values
   localparam int unsigned STAMP_AXES_LSB  = 5;
   localparam int unsigned STAMP_SEL_BIT   = 4;
   localparam int unsigned STAMP_EXT_BIT   = 3;
   localparam int unsigned STAMP_POL_BIT   = 2;
   localparam int unsigned I3C_OFF_BIT     = 1;
   localparam logic [7:0]  STAMP_CTRL_WMASK = 8'hFE;
   localparam logic [7:0]  STAMP_CTRL_RST  = 8'hE0;
   localparam int unsigned TIME_EN_BIT     = 5;
   localparam logic [7:0]  TIME_CTRL_WMASK = 8'h20;
   localparam logic [7:0]  TIME_CTRL_RST   = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // sticky flag positions
   localparam int unsigned FLG_W     = 24;
   localparam int unsigned FLG_FF    = 0;
   localparam int unsigned FLG_WU    = 1;
   localparam int unsigned FLG_STAP  = 2;
   localparam int unsigned FLG_DTAP  = 3;
   localparam int unsigned FLG_D6D   = 4;
   localparam int unsigned FLG_SLCHG = 5;
   localparam int unsigned FLG_WUAX  = 6;
   localparam int unsigned FLG_TAPANY = 9;
   localparam int unsigned FLG_TAPAX = 10;
   localparam int unsigned FLG_ORAX  = 13;
   localparam int unsigned FLG_WARN  = 19;
   localparam int unsigned FLG_DENRDY = 20;
   localparam int unsigned FLG_SAMPLE = 21;
   localparam logic [23:0] FLG_RST   = 24'h000000;
   localparam logic [23:0] CLR_ALL   = 24'h08003F;
   localparam logic [23:0] CLR_WAKE  = 24'h0001E3;
   localparam logic [23:0] CLR_TAP   = 24'h001E0C;
   localparam logic [23:0] CLR_ORIENT = 24'h17E010;
   localparam logic [23:0] CLR_SAMPLE = 24'hE00000;
   localparam logic [23:0] CLR_DENRDY = 24'h100000;

   ////////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mses_reg_req_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } mses_axes_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] value;
   } mses_temp_t;

   typedef struct packed {
      logic       freefall;
      logic       wakeup;
      logic [2:0] wakeAxes;
      logic       sleepState;
      logic       sleepChange;
      logic       singleTap;
      logic       doubleTap;
      logic       tapSign;
      logic [2:0] tapAxes;
      logic       orientChange;
      logic [5:0] orientAxes;
   } mses_events_t;

endpackage

// ==== bench/mses_host_model.sv ====
// host model that issues byte reads and writes on the register port
`timescale 1ns/100ps
`default_nettype none

module mses_host_model (
   input  wire logic               clk,
   output var mses_pkg::mses_reg_req_t regReq,
   input  wire logic               regRvalid,
   input  wire logic [7:0]         regRdata
);
   import mses_pkg::*;

   initial begin
      regReq = '0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one-cycle strobe, launched and dropped on falling edges
   task automatic wrReg(input logic [7:0] addr, input logic [7:0] data);
      logic [7:0] val;
      val = data;
      if (addr == ADDR_STAMP_CTRL) val[0] = 1'b0;
      if (addr == ADDR_TIME_CTRL) val = val & TIME_CTRL_WMASK;
      @(negedge clk);
      regReq <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: val};
      @(negedge clk);
      regReq.wr <= 1'b0;
   endtask

   // answer is expected one edge after the strobe; a late one is waited for briefly
   task automatic rdReg(input logic [7:0] addr, output logic [7:0] data);
      int n;
      data = 'x;
      @(negedge clk);
      regReq <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
      @(negedge clk);
      regReq.rd <= 1'b0;
      n = 0;
      while (regRvalid !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      if (regRvalid === 1'b1) data = regRdata;
   endtask
endmodule

`default_nettype wire

// ==== bench/mses_event_status_regs_tb.sv ====
// self-checking bench for the event, status and stamping register bank
`timescale 1ns/100ps
`default_nettype none

module mses_event_status_regs_tb;
   import mses_pkg::*;

   logic           clk;
   logic           reset_n;
   mses_reg_req_t  regReq;
   logic           regRvalid;
   logic [7:0]     regRdata;
   logic           dataEnablePin;
   logic           readyPulseMode;
   logic           accelHighPerf;
   logic [15:0]    outputSampleRate;
   mses_axes_t     gyroIn;
   mses_axes_t     accelIn;
   mses_axes_t     gyroOut;
   mses_axes_t     accelOut;
   mses_temp_t     tempIn;
   mses_events_t   events;
   logic [15:0]    accelFirstLowpassHz;
   logic           i3cDisable;
   logic [7:0]     t0;
   logic [7:0]     t1;
   int             miscompares;
   int             total_checks;
   logic [7:0]     rstAddr [11] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E,
                                    8'h1F, 8'h20, 8'h21, 8'h22};
   logic [7:0]     rstVal  [11] = '{8'hE0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                    8'h00, 8'h00, 8'h00, 8'h00};

   mses_event_status_regs #(.TICK_CYC(4)) DUT (
      .clk(clk), .reset_n(reset_n), .regReq(regReq), .regRvalid(regRvalid),
      .regRdata(regRdata), .dataEnablePin(dataEnablePin), .readyPulseMode(readyPulseMode),
      .accelHighPerf(accelHighPerf), .outputSampleRate(outputSampleRate),
      .gyroIn(gyroIn), .accelIn(accelIn), .tempIn(tempIn), .events(events),
      .gyroOut(gyroOut), .accelOut(accelOut),
      .accelFirstLowpassHz(accelFirstLowpassHz), .i3cDisable(i3cDisable));

   mses_host_model HOST (
      .clk(clk), .regReq(regReq), .regRvalid(regRvalid), .regRdata(regRdata));

   always #5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   // shared checks and stimulus
   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rdChk(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      HOST.rdReg(addr, d);
      chk($sformatf("reg %h", addr), {40'h0, exp}, {40'h0, d});
      if ($isunknown(d)) summarize();
   endtask

   // event pulse lasts one cycle; sleep state is a level and stays
   task automatic fire(input mses_events_t ev);
      mses_events_t idle;
      idle = '0;
      idle.sleepState = ev.sleepState;
      @(negedge clk);
      events <= ev;
      @(negedge clk);
      events <= idle;
   endtask

   task automatic sample(input logic [15:0] v, input logic [47:0] gExp, input logic [47:0] aExp);
      @(negedge clk);
      gyroIn <= '{valid: 1'b1, x: v, y: v, z: v};
      accelIn <= '{valid: 1'b1, x: v, y: v, z: v};
      @(negedge clk);
      gyroIn.valid <= 1'b0;
      accelIn.valid <= 1'b0;
      chk("out valid", 48'h3, {46'h0, gyroOut.valid, accelOut.valid});
      chk("gyro axes", gExp, {gyroOut.x, gyroOut.y, gyroOut.z});
      chk("accel axes", aExp, {accelOut.x, accelOut.y, accelOut.z});
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      summarize();
   end

   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      dataEnablePin = 1'b0;
      accelHighPerf = 1'b0;
      readyPulseMode = 1'b0;
      outputSampleRate = 16'h0341;
      gyroIn = '0;
      accelIn = '0;
      tempIn = '0;
      events = '0;
      miscompares = 0;
      total_checks = 0;
      repeat (12) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      chk("lowpass", {32'h0, LOWPASS_FIXED_HZ}, {32'h0, accelFirstLowpassHz});
      foreach (rstAddr[i]) rdChk(rstAddr[i], rstVal[i]);
      $display("test reset values done");

      HOST.wrReg(8'h18, 8'hE3);
      rdChk(8'h18, 8'hE2);
      repeat (2) @(negedge clk);
      chk("i3c off", 48'h1, {47'h0, i3cDisable});
      $display("test control write done");

      fire('{freefall: 1'b1, wakeup: 1'b1, wakeAxes: 3'b101, sleepChange: 1'b1, default: '0});
      rdChk(8'h1B, 8'h6D);
      rdChk(8'h1B, 8'h00);
      fire('{freefall: 1'b1, wakeup: 1'b1, wakeAxes: 3'b101, sleepChange: 1'b1, default: '0});
      rdChk(8'h1A, 8'h23);
      rdChk(8'h1A, 8'h00);
      rdChk(8'h1B, 8'h05);
      fire('{sleepState: 1'b1, default: '0});
      rdChk(8'h1B, 8'h10);
      fire('{default: '0});
      $display("test wake sources done");

      fire('{singleTap: 1'b1, tapSign: 1'b1, tapAxes: 3'b010, default: '0});
      rdChk(8'h1C, 8'h6A);
      fire('{doubleTap: 1'b1, tapAxes: 3'b001, default: '0});
      rdChk(8'h1C, 8'h51);
      rdChk(8'h1A, 8'h00);
      $display("test tap sources done");

      // stamping: active-high pin until the E0h write, so pin level and active state agree before it
      HOST.wrReg(8'h18, 8'hA4);
      dataEnablePin = 1'b1;
      repeat (3) @(negedge clk);
      sample(16'h1234, 48'h1235_1234_1235, 48'h1234_1234_1234);
      HOST.wrReg(8'h18, 8'h5C);
      repeat (2) @(negedge clk);
      sample(16'h1234, 48'h1234_1234_1234, 48'h1234_1235_1234);
      dataEnablePin = 1'b0;
      repeat (3) @(negedge clk);
      sample(16'h1235, 48'h1235_1235_1235, 48'h1235_1234_1235);
      @(negedge clk);
      tempIn <= '{valid: 1'b1, value: 16'h8A35};
      @(negedge clk);
      tempIn.valid <= 1'b0;
      rdChk(8'h1E, 8'h07);
      rdChk(8'h1E, 8'h00);
      rdChk(8'h20, 8'h35);
      rdChk(8'h21, 8'h8A);
      fire('{orientChange: 1'b1, orientAxes: 6'b100101, default: '0});
      rdChk(8'h1D, 8'hE5);
      rdChk(8'h1D, 8'h00);
      readyPulseMode = 1'b1;
      dataEnablePin = 1'b1;
      repeat (3) @(negedge clk);
      sample(16'h1234, 48'h1234_1234_1234, 48'h1234_1235_1234);
      rdChk(8'h1D, 8'h00);
      HOST.wrReg(8'h18, 8'hE0);
      sample(16'h1235, 48'h1234_1234_1234, 48'h1235_1235_1235);
      $display("test stamping and samples done");

      accelHighPerf = 1'b1;
      repeat (2) @(negedge clk);
      chk("lowpass", 48'h1A0, {32'h0, accelFirstLowpassHz});
      $display("test lowpass done");

      HOST.wrReg(8'h19, 8'h20);
      repeat (48) @(negedge clk);
      HOST.wrReg(8'h19, 8'h00);
      HOST.rdReg(8'h40, t0);
      HOST.rdReg(8'h40, t1);
      chk("time held", {40'h0, t0}, {40'h0, t1});
      chk("time ran", 48'h0C, {40'h0, t0});
      rdChk(8'h41, 8'h00);
      $display("test timestamp done");
      summarize();
   end
endmodule

`default_nettype wire
